// ### rtl/tcp_map.svh
// Address map, field positions, reset values and widths of the timer/PWM block.
// Assumes a 32-bit classic Wishbone slave port with byte addresses on adr[7:0].
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH

// Sizes
`define TCP_NCH        5
`define TCP_CW         16
`define TCP_DW         8
`define TCP_AW         8

// Address split: bank field selects a channel or the global bank
`define TCP_BANK_HI    7
`define TCP_BANK_LO    5
`define TCP_REG_HI     4
`define TCP_REG_LO     2
`define TCP_GLB_BANK   3'h5

// Per-channel register index (byte address = bank * 0x20 + index * 4)
`define TCP_R_CTRL     3'h0
`define TCP_R_PERIOD   3'h1
`define TCP_R_CMP      3'h2
`define TCP_R_DEAD     3'h3
`define TCP_R_COUNT    3'h4
`define TCP_R_CAPT     3'h5

// Global register index
`define TCP_R_STS      3'h0
`define TCP_R_MASK     3'h1

// Control fields
`define TCP_CTRL_EN    0
`define TCP_CTRL_ONE   1

// Interrupt layout: period event of channel n at bit n, capture at bit 8+n
`define TCP_IRQ_TC     0
`define TCP_IRQ_CAP    8
`define TCP_IRQ_W      13

// Reset values and fixed levels
`define TCP_PER_RST    16'hffff
`define TCP_CMP_RST    16'h0000
`define TCP_DEAD_RST   8'h00
`define TCP_KILL_LVL   1'b0
`define TCP_IDLE_LVL   1'b0

`endif

// ### rtl/tcp_pkg.sv
// Types shared by the timer/PWM top and its channel.
// Assumes tcp_map.svh for the widths.
`default_nettype none
`include "tcp_map.svh"

package tcp_pkg;

  typedef struct packed {
    logic                en;
    logic                oneshot;
    logic [`TCP_CW-1:0]  period;
    logic [`TCP_CW-1:0]  compare;
    logic [`TCP_DW-1:0]  dead;
  } tcp_cfg_t;

  typedef struct packed {
    logic [`TCP_CW-1:0]  count;
    logic [`TCP_CW-1:0]  capture;
    logic                tc;
    logic                cap;
  } tcp_stat_t;

endpackage : tcp_pkg

`default_nettype wire

// ### rtl/tcp_unit.sv
// One timer/counter/PWM channel: counter, capture, compare and dead band.
// Assumes capture_i is a one-cycle pulse and kill_i a level, both already synchronised.
`timescale 1ns/1ns
`default_nettype none
`include "tcp_map.svh"

module tcp_unit (
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Configuration and events
  input  wire tcp_pkg::tcp_cfg_t cfg_i,
  input  wire logic              capture_i,
  input  wire logic              kill_i,
  // State and outputs
  output var  tcp_pkg::tcp_stat_t stat_o,
  output var  logic              pwm_o,
  output var  logic              pwm_n_o
);

  logic [`TCP_CW-1:0] cnt_r;
  logic [`TCP_CW-1:0] cnt_nxt;
  logic [`TCP_CW-1:0] cap_r;
  logic [`TCP_DW-1:0] dcnt_r;
  logic               halt_r;
  logic               line_r;
  logic               tc_r;
  logic               capev_r;

  wire match    = cfg_i.en && (cnt_r == cfg_i.period);
  wire run      = cfg_i.en && !halt_r;
  wire raw      = cfg_i.en && (cnt_r < cfg_i.compare);
  wire gap_done = (dcnt_r == '0);

  // Halted channel keeps its count; disabling clears it for a clean restart
  assign cnt_nxt = !cfg_i.en ? '0 :
                   !run      ? cnt_r :
                   match     ? (cfg_i.oneshot ? cnt_r : '0) :
                   cnt_r + 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r   <= '0;
      cap_r   <= '0;
      dcnt_r  <= '0;
      halt_r  <= 1'b0;
      line_r  <= 1'b0;
      tc_r    <= 1'b0;
      capev_r <= 1'b0;
      pwm_o   <= `TCP_IDLE_LVL;
      pwm_n_o <= `TCP_IDLE_LVL;
    end
    else if (ce_i)
    begin
      cnt_r   <= cnt_nxt;
      halt_r  <= cfg_i.en && (halt_r || (match && cfg_i.oneshot));
      tc_r    <= run && match;
      capev_r <= capture_i;
      if (capture_i)
        cap_r <= cnt_r;
      line_r  <= raw;
      // Each transition of the compare line restarts the dead band
      if (raw != line_r)
        dcnt_r <= cfg_i.dead;
      else if (!gap_done)
        dcnt_r <= dcnt_r - 1'b1;
      // Kill overrides everything and needs no software step
      pwm_o   <= kill_i ? `TCP_KILL_LVL : !cfg_i.en ? `TCP_IDLE_LVL : line_r && gap_done;
      pwm_n_o <= kill_i ? `TCP_KILL_LVL : !cfg_i.en ? `TCP_IDLE_LVL : !line_r && gap_done;
    end
  end

  assign stat_o = '{count: cnt_r, capture: cap_r, tc: tc_r, cap: capev_r};

  ////////////////////////////////////////////////////////////////////////////
  sequence s_counting;
    ce_i && cfg_i.en && !halt_r && (cnt_r != cfg_i.period);
  endsequence

  sequence s_match;
    ce_i && cfg_i.en && !halt_r && (cnt_r == cfg_i.period);
  endsequence

  property p_count_step;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    s_counting |=> (cnt_r == $past(cnt_r) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not advance by one");

  property p_reload;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    (s_match and !cfg_i.oneshot) |=> (cnt_r == '0) && tc_r;
  endproperty
  a_reload: assert property (p_reload) else $error("period match did not reload");

  property p_halt;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    (s_match and cfg_i.oneshot) |=> halt_r && (cnt_r == $past(cnt_r)) ##1 (cnt_r == $past(cnt_r, 2));
  endproperty
  a_halt: assert property (p_halt) else $error("one-shot counter did not stop at period");

  property p_capture;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    capture_i |=> (cap_r == $past(cnt_r)) && capev_r;
  endproperty
  a_capture: assert property (p_capture) else $error("capture did not latch the count");

  property p_compare;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    cfg_i.en |=> (line_r == ($past(cnt_r) < $past(cfg_i.compare)));
  endproperty
  a_compare: assert property (p_compare) else $error("compare line does not follow count");

  property p_dead;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    ($changed(line_r) && cfg_i.en && (cfg_i.dead != '0)) |=> (!pwm_o && !pwm_n_o);
  endproperty
  a_dead: assert property (p_dead) else $error("no dead band after a compare edge");

  property p_kill;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    kill_i |=> (pwm_o == `TCP_KILL_LVL) && (pwm_n_o == `TCP_KILL_LVL);
  endproperty
  a_kill: assert property (p_kill) else $error("kill did not force the outputs");

  property p_idle;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    (!cfg_i.en && !kill_i) |=> (pwm_o == `TCP_IDLE_LVL) && (pwm_n_o == `TCP_IDLE_LVL) && (cnt_r == '0);
  endproperty
  a_idle: assert property (p_idle) else $error("disabled channel not idle");

endmodule : tcp_unit

`default_nettype wire

// ### rtl/tcp_top.sv
// Five-channel timer/counter/PWM block with a classic Wishbone register port.
// Assumes capture and kill pins are asynchronous; everything else runs on clk_i.
//
// Notes on behaviour
// - Each channel counts on a 16-bit counter whose period software sets in a register.
// - A capture event, from a pin, latches the present count into the capture register.
// - When the count equals the period the channel either stops or reloads to zero, by a control bit.
// - The count is compared with the compare register and the result drives the PWM line.
// - A true and a complementary output are driven with a programmable dead band between edges.
// - The kill input forces both outputs to a fixed safe level with no software step.
// - Five independent channels are built.
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "tcp_map.svh"

module tcp_top (
  // Clock, reset, enable
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [`TCP_AW-1:0]   wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  output var  logic [31:0]          wb_dat_o,
  output var  logic                 wb_ack_o,
  // Pins
  input  wire logic [`TCP_NCH-1:0]  capture_i,
  input  wire logic [`TCP_NCH-1:0]  kill_i,
  output var  logic [`TCP_NCH-1:0]  pwm_o,
  output var  logic [`TCP_NCH-1:0]  pwm_n_o,
  // Interrupt
  output var  logic                 irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge of a write into an old register value
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[b*8 +: 8] = dat[b*8 +: 8];
    end
    return res;
  endfunction : wmerge

  // Zero-extend a count for the read path
  function automatic logic [31:0] zx16(input logic [`TCP_CW-1:0] v);
    return {{(32-`TCP_CW){1'b0}}, v};
  endfunction : zx16

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage and the capture edge delay cap_d_r feed logic
  logic [`TCP_NCH-1:0] kill_s1_r;
  logic [`TCP_NCH-1:0] kill_s2_r;
  logic [`TCP_NCH-1:0] cap_s1_r;
  logic [`TCP_NCH-1:0] cap_s2_r;
  logic [`TCP_NCH-1:0] cap_d_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      kill_s1_r <= '0;
      kill_s2_r <= '0;
      cap_s1_r  <= '0;
      cap_s2_r  <= '0;
      cap_d_r   <= '0;
    end
    else if (ce_i)
    begin
      kill_s1_r <= kill_i;
      kill_s2_r <= kill_s1_r;
      cap_s1_r  <= capture_i;
      cap_s2_r  <= cap_s1_r;
      cap_d_r   <= cap_s2_r;
    end
  end

  // Capture fires on the rising edge of the pin
  wire [`TCP_NCH-1:0] cap_evt = cap_s2_r & ~cap_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire       acc      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge where the master sees ack, as classic cycles require
  wire       wr       = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire [2:0] a_bank   = wb_adr_i[`TCP_BANK_HI:`TCP_BANK_LO];
  wire [2:0] a_reg    = wb_adr_i[`TCP_REG_HI:`TCP_REG_LO];
  wire       glb_hit  = (a_bank == `TCP_GLB_BANK);
  wire       ch_hit   = (a_bank < 3'(`TCP_NCH));
  wire       wr_sts   = wr && glb_hit && (a_reg == `TCP_R_STS);
  wire       wr_mask  = wr && glb_hit && (a_reg == `TCP_R_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Channel configuration registers
  tcp_pkg::tcp_cfg_t  cfg_r  [`TCP_NCH];
  tcp_pkg::tcp_stat_t stat_w [`TCP_NCH];

  logic [`TCP_IRQ_W-1:0] sts_r;
  logic [`TCP_IRQ_W-1:0] sts_nxt;
  logic [`TCP_IRQ_W-1:0] mask_r;
  logic [`TCP_IRQ_W-1:0] evt;
  logic [31:0]           rd_nxt;

  // Configuration of the addressed channel, the base for byte-lane merges
  tcp_pkg::tcp_cfg_t     cfg_cur;

  always_comb
  begin
    cfg_cur = cfg_r[0];
    for (int c = 0; c < `TCP_NCH; c++)
    begin
      if (a_bank == 3'(c))
        cfg_cur = cfg_r[c];
    end
  end

  wire [31:0] ctrl_m = wmerge({30'h0, cfg_cur.oneshot, cfg_cur.en}, wb_dat_i, wb_sel_i);
  wire [31:0] per_m  = wmerge(zx16(cfg_cur.period), wb_dat_i, wb_sel_i);
  wire [31:0] cmp_m  = wmerge(zx16(cfg_cur.compare), wb_dat_i, wb_sel_i);
  wire [31:0] dead_m = wmerge({24'h0, cfg_cur.dead}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < `TCP_NCH; c++)
      begin
        cfg_r[c].en      <= 1'b0;
        cfg_r[c].oneshot <= 1'b0;
        cfg_r[c].period  <= `TCP_PER_RST;
        cfg_r[c].compare <= `TCP_CMP_RST;
        cfg_r[c].dead    <= `TCP_DEAD_RST;
      end
    end
    else if (ce_i && wr && ch_hit)
    begin
      for (int c = 0; c < `TCP_NCH; c++)
      begin
        if (a_bank == 3'(c))
        begin
          unique case (a_reg)
            `TCP_R_CTRL:
            begin
              cfg_r[c].en      <= ctrl_m[`TCP_CTRL_EN];
              cfg_r[c].oneshot <= ctrl_m[`TCP_CTRL_ONE];
            end
            `TCP_R_PERIOD:
            begin
              cfg_r[c].period <= per_m[`TCP_CW-1:0];
            end
            `TCP_R_CMP:
            begin
              cfg_r[c].compare <= cmp_m[`TCP_CW-1:0];
            end
            `TCP_R_DEAD:
            begin
              cfg_r[c].dead <= dead_m[`TCP_DW-1:0];
            end
            // Read-only and unused indexes ignore writes
            default:
            begin
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  genvar g;
  generate
    for (g = 0; g < `TCP_NCH; g++)
    begin : gen_ch
      tcp_unit u_ch (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .cfg_i     (cfg_r[g]),
        .capture_i (cap_evt[g]),
        .kill_i    (kill_s2_r[g]),
        .stat_o    (stat_w[g]),
        .pwm_o     (pwm_o[g]),
        .pwm_n_o   (pwm_n_o[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: events win over a write-one clear in the same cycle
  always_comb
  begin
    evt = '0;
    for (int c = 0; c < `TCP_NCH; c++)
    begin
      evt[`TCP_IRQ_TC + c]  = stat_w[c].tc;
      evt[`TCP_IRQ_CAP + c] = stat_w[c].cap;
    end
  end

  wire [31:0]           clr_word  = wmerge(32'h0, wb_dat_i, wb_sel_i);
  wire [31:0]           mask_word = wmerge({19'h0, mask_r}, wb_dat_i, wb_sel_i);
  wire [`TCP_IRQ_W-1:0] clr_bits  = wr_sts ? clr_word[`TCP_IRQ_W-1:0] : '0;
  wire [`TCP_IRQ_W-1:0] mask_nxt  = wr_mask ? mask_word[`TCP_IRQ_W-1:0] : mask_r;
  assign sts_nxt = (sts_r & ~clr_bits) | evt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sts_r  <= '0;
      mask_r <= '0;
      irq_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      sts_r <= sts_nxt;
      mask_r <= mask_nxt;
      // Registered from next-state values so irq_o moves on the same edge as status
      irq_o  <= |(sts_nxt & mask_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped addresses read as zero and are still acknowledged
  always_comb
  begin
    rd_nxt = '0;
    if (glb_hit)
    begin
      if (a_reg == `TCP_R_STS)
        rd_nxt = {19'h0, sts_r};
      else if (a_reg == `TCP_R_MASK)
        rd_nxt = {19'h0, mask_r};
    end
    else
    begin
      for (int c = 0; c < `TCP_NCH; c++)
      begin
        if (a_bank == 3'(c))
        begin
          unique case (a_reg)
            `TCP_R_CTRL:   rd_nxt = {30'h0, cfg_r[c].oneshot, cfg_r[c].en};
            `TCP_R_PERIOD: rd_nxt = zx16(cfg_r[c].period);
            `TCP_R_CMP:    rd_nxt = zx16(cfg_r[c].compare);
            `TCP_R_DEAD:   rd_nxt = {24'h0, cfg_r[c].dead};
            `TCP_R_COUNT:  rd_nxt = zx16(stat_w[c].count);
            `TCP_R_CAPT:   rd_nxt = zx16(stat_w[c].capture);
            default:       rd_nxt = '0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i)
        wb_dat_o <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  property p_kill_path;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    kill_i[0] ##1 kill_i[0] ##1 kill_i[0] |=> (pwm_o[0] == `TCP_KILL_LVL);
  endproperty
  a_kill_path: assert property (p_kill_path) else $error("kill pin did not reach channel 0");

  property p_ack_latency;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_latency: assert property (p_ack_latency) else $error("request not acknowledged next cycle");

  property p_rd_hold;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    !(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");

  property p_sts_set;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    (evt != '0) |=> ((sts_r & $past(evt)) == $past(evt));
  endproperty
  a_sts_set: assert property (p_sts_set) else $error("event did not set its status bit");

  property p_irq_level;
    @(posedge clk_i) disable iff (rst_i)
    irq_o == |(sts_r & mask_r);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt line disagrees with status and mask");

endmodule : tcp_top

`default_nettype wire

// ### testbench/tcp_far_end.sv
// Far-side model: event source on the capture pins, fault sensor on the kill pins,
// gate drivers on the PWM pins. Assumes the bench clock; pins change just after a rising edge.
`timescale 1ns/1ns
`default_nettype none

module tcp_far_end (
  // Clock
  input  wire logic       clk_i,
  // Pins toward the timer
  output var  logic [4:0] capture_o,
  output var  logic [4:0] kill_o,
  input  wire logic [4:0] pwm_i,
  input  wire logic [4:0] pwm_n_i,
  // Cycles with both switches of a leg closed
  output var  int         shoot_o
);
  initial
  begin
    capture_o = 5'h00;
    kill_o    = 5'h00;
    shoot_o   = 0;
  end

  // Both switches of one leg closed would short the supply
  always @(posedge clk_i)
    if ((pwm_i & pwm_n_i) != 5'h00)
      shoot_o <= shoot_o + 1;

  ////////////////////////////////////////
  // Held several cycles so the pin synchroniser cannot miss the edge
  task pulse_capture(input int ch);
    @(posedge clk_i);
    capture_o[ch] <= 1'b1;
    repeat (4) @(posedge clk_i);
    capture_o[ch] <= 1'b0;
  endtask : pulse_capture

  task set_kill(input int ch, input logic lvl);
    @(posedge clk_i);
    kill_o[ch] <= lvl;
  endtask : set_kill
endmodule : tcp_far_end
`default_nettype wire

// ### testbench/timer_counter_pwm_unit_tb.sv
// Self-checking bench for the five-channel timer/PWM block.
// Assumes tcp_top with its Wishbone port and tcp_far_end on the pins.
`timescale 1ns/1ns
`default_nettype none
`include "tcp_map.svh"

module timer_counter_pwm_unit_tb;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        ce_i     = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  logic [4:0]  capture_i;
  logic [4:0]  kill_i;
  logic [4:0]  pwm_o;
  logic [4:0]  pwm_n_o;
  int          shoot;
  int          failures   = 0;
  int          num_checks = 0;
  int          seed       = 32'h2814;
  logic [31:0] exp_q[$];
  logic [15:0] per[5];
  logic [15:0] cmp[5];
  logic [7:0]  dead[5];
  logic [9:0]  frz;

  always #2 clk_i = ~clk_i;

  tcp_top u_dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
                 .wb_sel_i, .wb_dat_o, .wb_ack_o, .capture_i, .kill_i, .pwm_o, .pwm_n_o, .irq_o);
  tcp_far_end u_far (.clk_i(clk_i), .capture_o(capture_i), .kill_o(kill_i), .pwm_i(pwm_o),
                     .pwm_n_i(pwm_n_o), .shoot_o(shoot));

  ////////////////////////////////////////
  task final_report;
    if (failures == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  function logic [7:0] ra(input int bank, input logic [2:0] idx);
    ra = {bank[2:0], idx, 2'b00};
  endfunction : ra

  // Classic cycle: no assumed latency, held until ack is sampled high
  task xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [31:0] exp);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    if (!we)
      exp_q.push_back(exp);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 64);
    if (wb_ack_o !== 1'b1)
      failures++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat, 32'h0);
  endtask : wr

  task rd(input logic [7:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0, exp);
  endtask : rd

  // Read data is judged at the edge where the master takes it
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      check(wb_dat_o, exp_q.pop_front(), "read data");

  // High cycles of both outputs over whole PWM periods
  task duty(input int ch, input int len, input int exp_hi, input int exp_lo);
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    repeat (len)
    begin
      @(posedge clk_i);
      hi += (pwm_o[ch] === 1'b1);
      lo += (pwm_n_o[ch] === 1'b1);
    end
    check(hi, exp_hi, "true output duty");
    check(lo, exp_lo, "complement duty");
  endtask : duty

  ////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    final_report();
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int n = 0; n < 5; n++)
    begin
      rd(ra(n, `TCP_R_CTRL), 32'h0);
      rd(ra(n, `TCP_R_PERIOD), 32'h0000ffff);
      rd(ra(n, `TCP_R_COUNT), 32'h0);
    end
    rd(ra(`TCP_GLB_BANK, `TCP_R_STS), 32'h0);
    rd(8'hc0, 32'h0);
    check({pwm_o, pwm_n_o}, 32'h0, "idle outputs");
    wr(ra(0, `TCP_R_COUNT), 32'h1234);
    rd(ra(0, `TCP_R_COUNT), 32'h0);
    // Random period, compare and dead band on every channel
    for (int n = 0; n < 5; n++)
    begin
      per[n]  = 16'h10 | 16'($random(seed) & 15);
      cmp[n]  = 16'h6 + 16'($random(seed) & 7);
      dead[n] = 8'($random(seed) & 3);
      wr(ra(n, `TCP_R_PERIOD), {16'h0, per[n]});
      wr(ra(n, `TCP_R_CMP), {16'h0, cmp[n]});
      wr(ra(n, `TCP_R_DEAD), {24'h0, dead[n]});
      rd(ra(n, `TCP_R_PERIOD), {16'h0, per[n]});
      wr(ra(n, `TCP_R_CTRL), 32'h1);
    end
    repeat (100) @(posedge clk_i);
    for (int n = 0; n < 5; n++)
      duty(n, 4 * (per[n] + 1), 4 * (cmp[n] - dead[n]), 4 * (per[n] + 1 - cmp[n] - dead[n]));
    rd(ra(`TCP_GLB_BANK, `TCP_R_STS), 32'h1f);
    check(irq_o, 1'b0, "masked interrupt");
    wr(ra(`TCP_GLB_BANK, `TCP_R_MASK), 32'h4);
    rd(ra(`TCP_GLB_BANK, `TCP_R_MASK), 32'h4);
    check(irq_o, 1'b1, "unmasked interrupt");
    // Kill one channel; its neighbour must keep running
    u_far.set_kill(2, 1'b1);
    repeat (4) @(posedge clk_i);
    duty(2, 2 * (per[2] + 1), 0, 0);
    duty(3, 4 * (per[3] + 1), 4 * (cmp[3] - dead[3]), 4 * (per[3] + 1 - cmp[3] - dead[3]));
    u_far.set_kill(2, 1'b0);
    repeat (60) @(posedge clk_i);
    duty(2, 4 * (per[2] + 1), 4 * (cmp[2] - dead[2]), 4 * (per[2] + 1 - cmp[2] - dead[2]));
    // Clock enable low must freeze the running channels, outputs included
    @(posedge clk_i);
    ce_i <= 1'b0;
    @(posedge clk_i);
    frz = {pwm_o, pwm_n_o};
    repeat (20)
    begin
      @(posedge clk_i);
      check({pwm_o, pwm_n_o}, frz, "frozen outputs");
    end
    ce_i <= 1'b1;
    // One-shot halt, then capture of the held count
    for (int n = 0; n < 5; n++)
      wr(ra(n, `TCP_R_CTRL), 32'h0);
    wr(ra(`TCP_GLB_BANK, `TCP_R_STS), 32'h1fff);
    rd(ra(`TCP_GLB_BANK, `TCP_R_STS), 32'h0);
    check(irq_o, 1'b0, "cleared interrupt");
    wr(ra(0, `TCP_R_CTRL), 32'h3);
    repeat (3 * per[0]) @(posedge clk_i);
    rd(ra(0, `TCP_R_COUNT), {16'h0, per[0]});
    rd(ra(0, `TCP_R_COUNT), {16'h0, per[0]});
    u_far.pulse_capture(0);
    repeat (6) @(posedge clk_i);
    rd(ra(0, `TCP_R_CAPT), {16'h0, per[0]});
    rd(ra(`TCP_GLB_BANK, `TCP_R_STS), 32'h101);
    wr(ra(`TCP_GLB_BANK, `TCP_R_MASK), 32'h100);
    repeat (3) @(posedge clk_i);
    check(irq_o, 1'b1, "capture interrupt");
    wr(ra(`TCP_GLB_BANK, `TCP_R_STS), 32'h100);
    rd(ra(`TCP_GLB_BANK, `TCP_R_STS), 32'h1);
    check(irq_o, 1'b0, "capture interrupt cleared");
    check(shoot, 32'h0, "shoot-through cycles");
    repeat (4) @(posedge clk_i);
    final_report();
  end
endmodule : timer_counter_pwm_unit_tb
`default_nettype wire
